// ===== logic/tmr_pkg.sv
package tmr_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] TIMER_MODE_CONTROL_ADDR = 8'h89;
  localparam logic [7:0] TIMER_RUN_FLAG_ADDR     = 8'h88;
  localparam logic [7:0] COUNT_LOW0_ADDR         = 8'h8A;
  localparam logic [7:0] COUNT_LOW1_ADDR         = 8'h8B;
  localparam logic [7:0] COUNT_HIGH0_ADDR        = 8'h8C;
  localparam logic [7:0] COUNT_HIGH1_ADDR        = 8'h8D;
  localparam logic [7:0] MODE_RESET              = 8'h00;
  localparam logic [7:0] CTRL_RESET              = 8'h00;
  localparam logic [7:0] COUNT_RESET             = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int UNIT1_FIELD_BASE = 4;
  localparam int UNIT0_FIELD_BASE = 0;
  localparam int GATE_POS         = 3;
  localparam int SRC_POS          = 2;
  localparam int MODE_HI_POS      = 1;
  localparam int MODE_LO_POS      = 0;
  localparam int OVF1_POS         = 7;
  localparam int RUN1_POS         = 6;
  localparam int OVF0_POS         = 5;
  localparam int RUN0_POS         = 4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int OSC_PER_MCYCLE = 6;

  typedef enum logic [1:0]
  {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } count_mode_t;
endpackage

// ===== logic/mcycle_divider.sv
`timescale 1ns/1ps
`default_nettype none
module mcycle_divider
#(
  parameter int DIV = tmr_pkg::OSC_PER_MCYCLE
)
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Machine cycle enable
  output logic      mcycle_en
);
  import tmr_pkg::*;

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       en_q;
  logic       en_d;

  // One pulse every DIV oscillator cycles
  always_comb
  begin
    en_d  = (cnt_q == 4'(DIV - 1));
    cnt_d = en_d ? 4'h0 : cnt_q + 4'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cnt_q <= 4'h0;
      en_q  <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      en_q  <= en_d;
    end
  end

  assign mcycle_en = en_q;
endmodule // mcycle_divider
`default_nettype wire

// ===== logic/pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sampler
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic mcycle_en,
  // Pin
  input  wire logic pin,
  // Results
  output logic      level,
  output logic      fall
);
  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic       samp_q;
  logic       samp_d;
  logic       fall_q;
  logic       fall_d;

  // Two-flop synchroniser, then one sample per machine cycle
  always_comb
  begin
    sync_d = {sync_q[0], pin};
    samp_d = mcycle_en ? sync_q[1] : samp_q;
    fall_d = mcycle_en & samp_q & ~sync_q[1];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      sync_q <= 2'b00;
      samp_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      sync_q <= sync_d;
      samp_q <= samp_d;
      fall_q <= fall_d;
    end
  end

  assign level = samp_q;
  assign fall  = fall_q;
endmodule // pin_sampler
`default_nettype wire

// ===== logic/dual_timer_counter.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Pins
  input  wire logic       count_pin_unit0,
  input  wire logic       count_pin_unit1,
  input  wire logic       external_interrupt_pin0,
  input  wire logic       external_interrupt_pin1,
  // Interrupt vectoring acknowledge
  input  wire logic       vector_ack0,
  input  wire logic       vector_ack1,
  // Overflow flags
  output logic            overflow_flag0,
  output logic            overflow_flag1
);
  import tmr_pkg::*;

  // ****************************************************************
  // Machine cycle and pin sampling
  // ****************************************************************
  logic mcycle_en;
  logic cnt_lvl0;
  logic cnt_fall0;
  logic cnt_lvl1;
  logic cnt_fall1;
  logic int_lvl0;
  logic int_lvl1;

  mcycle_divider #(.DIV(OSC_PER_MCYCLE)) u_div
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .mcycle_en (mcycle_en)
  );

  // Falls are flagged one cycle after the sampling enable; counting then
  // happens on the next machine cycle so the value shows one cycle later.
  pin_sampler u_cnt0
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .mcycle_en (mcycle_en),
    .pin       (count_pin_unit0),
    .level     (cnt_lvl0),
    .fall      (cnt_fall0)
  );

  pin_sampler u_cnt1
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .mcycle_en (mcycle_en),
    .pin       (count_pin_unit1),
    .level     (cnt_lvl1),
    .fall      (cnt_fall1)
  );

  pin_sampler u_int0
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .mcycle_en (mcycle_en),
    .pin       (external_interrupt_pin0),
    .level     (int_lvl0),
    .fall      ()
  );

  pin_sampler u_int1
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .mcycle_en (mcycle_en),
    .pin       (external_interrupt_pin1),
    .level     (int_lvl1),
    .fall      ()
  );

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] low_q [2];
  logic [7:0] low_d [2];
  logic [7:0] high_q [2];
  logic [7:0] high_d [2];
  logic       pend_q [2];
  logic       pend_d [2];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Unit enable: run, and pin high when gating
  function automatic logic unit_enable(input logic run, input logic gate, input logic int_lvl);
    unit_enable = run & (~gate | int_lvl);
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [3:0]  fld [2];
  logic        run [2];
  logic        en [2];
  logic        tick [2];
  logic        ovf [2];
  logic        hi_ovf;
  count_mode_t md [2];
  logic [15:0] c16;
  logic [12:0] c13;
  logic [8:0]  c9;

  always_comb
  begin
    mode_d  = mode_q;
    ctrl_d  = ctrl_q;
    rdata_d = 8'h00;
    hi_ovf  = 1'b0;
    c16     = 16'h0000;
    c13     = 13'h0000;
    c9      = 9'h000;
    fld[0]  = mode_q[UNIT0_FIELD_BASE +: 4];
    fld[1]  = mode_q[UNIT1_FIELD_BASE +: 4];
    run[0]  = ctrl_q[RUN0_POS];
    run[1]  = ctrl_q[RUN1_POS];
    for (int u = 0; u < 2; u++)
    begin
      low_d[u]  = low_q[u];
      high_d[u] = high_q[u];
      ovf[u]    = 1'b0;
      md[u]     = count_mode_t'(fld[u][MODE_HI_POS:MODE_LO_POS]);
      en[u]     = unit_enable(run[u], fld[u][GATE_POS], (u == 0) ? int_lvl0 : int_lvl1);
      // Pending fall counts on the next machine cycle, never the same one
      pend_d[u] = pend_q[u];
      if ((u == 0) ? cnt_fall0 : cnt_fall1)
        pend_d[u] = 1'b1;
      // Source choice: machine cycles or recorded pin falls
      if (fld[u][SRC_POS])
        tick[u] = mcycle_en & pend_q[u];
      else
        tick[u] = mcycle_en;
      if (mcycle_en)
        pend_d[u] = (u == 0) ? cnt_fall0 : cnt_fall1;
    end

    // Unit 1 is stopped in its own split mode
    if (md[1] == MODE_SPLIT)
      en[1] = 1'b0;

    for (int u = 0; u < 2; u++)
    begin
      if (en[u] && tick[u])
      begin
        unique case (md[u])
          MODE_13BIT:
          begin
            c13       = {high_q[u], low_q[u][4:0]} + 13'h0001;
            high_d[u] = c13[12:5];
            low_d[u]  = {low_q[u][7:5], c13[4:0]};
            ovf[u]    = (c13 == 13'h0000);
          end
          MODE_16BIT:
          begin
            c16       = {high_q[u], low_q[u]} + 16'h0001;
            high_d[u] = c16[15:8];
            low_d[u]  = c16[7:0];
            ovf[u]    = (c16 == 16'h0000);
          end
          MODE_RELOAD:
          begin
            c9     = {1'b0, low_q[u]} + 9'h001;
            ovf[u] = c9[8];
            low_d[u] = c9[8] ? high_q[u] : c9[7:0];
          end
          MODE_SPLIT:
          begin
            c9       = {1'b0, low_q[u]} + 9'h001;
            low_d[u] = c9[7:0];
            ovf[u]   = c9[8];
          end
        endcase
      end
    end

    // Split unit 0 high half: machine cycles under unit 1 run bit
    if (md[0] == MODE_SPLIT && run[1] && mcycle_en)
    begin
      high_d[0] = high_q[0] + 8'h01;
      hi_ovf    = (high_q[0] == 8'hFF);
    end

    // Register writes; hardware overflow set wins over software clear
    if (reg_wr)
    begin
      unique case (reg_addr)
        TIMER_MODE_CONTROL_ADDR: mode_d = reg_wdata;
        TIMER_RUN_FLAG_ADDR:     ctrl_d = reg_wdata;
        COUNT_LOW0_ADDR:         low_d[0] = reg_wdata;
        COUNT_LOW1_ADDR:         low_d[1] = reg_wdata;
        COUNT_HIGH0_ADDR:        high_d[0] = reg_wdata;
        COUNT_HIGH1_ADDR:        high_d[1] = reg_wdata;
        default:                 ;
      endcase
    end
    if (vector_ack0)
      ctrl_d[OVF0_POS] = 1'b0;
    if (vector_ack1)
      ctrl_d[OVF1_POS] = 1'b0;
    if (ovf[0])
      ctrl_d[OVF0_POS] = 1'b1;
    // In split mode unit 1 flag belongs to the unit 0 high half
    if ((md[0] == MODE_SPLIT) ? hi_ovf : ovf[1])
      ctrl_d[OVF1_POS] = 1'b1;

    // Read data; unmapped reads return zero
    if (reg_rd)
    begin
      unique case (reg_addr)
        TIMER_MODE_CONTROL_ADDR: rdata_d = mode_q;
        TIMER_RUN_FLAG_ADDR:     rdata_d = ctrl_q;
        COUNT_LOW0_ADDR:         rdata_d = low_q[0];
        COUNT_LOW1_ADDR:         rdata_d = low_q[1];
        COUNT_HIGH0_ADDR:        rdata_d = high_q[0];
        COUNT_HIGH1_ADDR:        rdata_d = high_q[1];
        default:                 rdata_d = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mode_q  <= MODE_RESET;
      ctrl_q  <= CTRL_RESET;
      rdata_q <= 8'h00;
      for (int u = 0; u < 2; u++)
      begin
        low_q[u]  <= COUNT_RESET;
        high_q[u] <= COUNT_RESET;
        pend_q[u] <= 1'b0;
      end
    end
    else
    begin
      mode_q  <= mode_d;
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      for (int u = 0; u < 2; u++)
      begin
        low_q[u]  <= low_d[u];
        high_q[u] <= high_d[u];
        pend_q[u] <= pend_d[u];
      end
    end
  end

  assign reg_rdata      = rdata_q;
  assign overflow_flag0 = ctrl_q[OVF0_POS];
  assign overflow_flag1 = ctrl_q[OVF1_POS];
endmodule // dual_timer_counter
`default_nettype wire

// ===== tb/dual_timer_counter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module timer_port_checker
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Flags
  input wire logic       vector_ack0,
  input wire logic       vector_ack1,
  input wire logic       overflow_flag0,
  input wire logic       overflow_flag1
);
  logic [7:0] mode_q, mode_d, run_q, run_d;
  // Mirror of software settings, which hardware never alters
  always_comb
  begin
    mode_d = (reg_wr && reg_addr == TIMER_MODE_CONTROL_ADDR) ? reg_wdata : mode_q;
    run_d  = (reg_wr && reg_addr == TIMER_RUN_FLAG_ADDR) ? reg_wdata : run_q;
  end
  always_ff @(posedge sys_clk)
  begin
    mode_q <= rst_b ? mode_d : 8'h00;
    run_q  <= rst_b ? run_d : 8'h00;
  end
  wire t0_free = mode_q[3:0] == 4'h1 && run_q[4];
  wire t1_stop = mode_q[5:4] == 2'b11;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  // Low byte read twice six cycles apart
  property p_step(logic go, logic [7:0] a, logic [7:0] inc);
    (go && reg_rd && reg_addr == a) ##6 s_rd(a) |=> reg_rdata == $past(reg_rdata, 6) + inc;
  endproperty
  AST_MODE_READBACK: assert property (s_wr(TIMER_MODE_CONTROL_ADDR) ##1 s_rd(TIMER_MODE_CONTROL_ADDR)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("mode readback wrong");
  AST_UNMAPPED_READ: assert property (reg_rd && (reg_addr < 8'h88 || reg_addr > 8'h8D)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_FLAG_VISIBLE: assert property (s_rd(TIMER_RUN_FLAG_ADDR) |=> reg_rdata[7] == $past(overflow_flag1)
    && reg_rdata[5] == $past(overflow_flag0)) else $error("flag port and bit differ");
  AST_RUN_READBACK: assert property (s_wr(TIMER_RUN_FLAG_ADDR) ##1 s_rd(TIMER_RUN_FLAG_ADDR)
    |=> (reg_rdata & 8'h5F) == ($past(reg_wdata, 2) & 8'h5F)) else $error("run bits lost");
  AST_OVF0_CLEAR: assert property ($fell(overflow_flag0) |-> $past(vector_ack0)
    || $past(reg_wr && reg_addr == TIMER_RUN_FLAG_ADDR && !reg_wdata[5])) else $error("flag 0 fell alone");
  AST_OVF1_CLEAR: assert property ($fell(overflow_flag1) |-> $past(vector_ack1)
    || $past(reg_wr && reg_addr == TIMER_RUN_FLAG_ADDR && !reg_wdata[7])) else $error("flag 1 fell alone");
  AST_TIMER_RATE: assert property (p_step(t0_free, COUNT_LOW0_ADDR, 8'h01)) else $error("timer rate wrong");
  AST_UNIT1_HOLD: assert property (p_step(t1_stop, COUNT_LOW1_ADDR, 8'h00)) else $error("unit 1 moved");
endmodule // timer_port_checker
bind dual_timer_counter timer_port_checker u_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .vector_ack0, .vector_ack1, .overflow_flag0, .overflow_flag1);
`default_nettype wire

// ===== tb/pin_source.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Far-side pin source
// ****
module pin_source
#(
  parameter int HOLD = 12
)
(
  // Clock
  input  wire logic       sys_clk,
  // Bench requests
  input  wire logic       go,
  input  wire logic [3:0] n_falls,
  input  wire logic [1:0] gate_lvl,
  // Pins
  output logic            count_pin_unit0,
  output logic            count_pin_unit1,
  output logic            external_interrupt_pin0,
  output logic            external_interrupt_pin1,
  output logic            busy
);
  logic pin_q = 1'b1;
  // Both count pins share one wave; gating pins follow the bench
  assign count_pin_unit0 = pin_q;
  assign count_pin_unit1 = pin_q;
  assign external_interrupt_pin0 = gate_lvl[0];
  assign external_interrupt_pin1 = gate_lvl[1];
  // Levels held two machine cycles, so slow sampling never misses one
  initial
  begin
    busy = 1'b0;
    forever
    begin
      @(posedge sys_clk);
      if (go)
      begin
        busy <= 1'b1;
        repeat (n_falls)
        begin
          repeat (HOLD) @(posedge sys_clk);
          pin_q <= 1'b0;
          repeat (HOLD) @(posedge sys_clk);
          pin_q <= 1'b1;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // pin_source
`default_nettype wire

// ===== tb/tb_dual_timer_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module tb_dual_timer_counter;
  import tmr_pkg::*;
  logic        sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, rd_seen = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, h;
  logic        count_pin_unit0, count_pin_unit1, external_interrupt_pin0, external_interrupt_pin1;
  logic        overflow_flag0, overflow_flag1, busy;
  logic [1:0]  ack = 2'b00, gate_lvl = 2'b00;
  logic [16:0] exp_q[$], e;
  logic [31:0] rnd = 32'hB141;
  int          n_mismatch = 0, num_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  dual_timer_counter DUT (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .count_pin_unit0, .count_pin_unit1, .external_interrupt_pin0, .external_interrupt_pin1,
    .vector_ack0(ack[0]), .vector_ack1(ack[1]), .overflow_flag0, .overflow_flag1);
  pin_source u_src (.sys_clk, .go, .n_falls(4'h5), .gate_lvl, .count_pin_unit0, .count_pin_unit1,
    .external_interrupt_pin0, .external_interrupt_pin1, .busy);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] y);
    num_checks++;
    if (x !== y)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, y);
    end
  endtask
  // One cycle on the register port; strobes hold until the next call changes them
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, input logic [1:0] k);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    ack <= k;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d, 2'b00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic care = 1'b1);
    exp_q.push_back({care, a, x});
    bus(1'b0, 1'b1, a, 8'h00, 2'b00);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00, 2'b00);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait; c selects flag 0, flag 1 or the source going idle
  // Strobes drop first, so a last write or read is never repeated
  task automatic wait_on(input int c);
    idle(1);
    for (int i = 0; i < 400; i++)
    begin
      @(negedge sys_clk);
      if ((c == 0 ? overflow_flag0 : (c == 1 ? overflow_flag1 : !busy)) === 1'b1)
        return;
    end
    n_mismatch++;
    $display("[FAIL] wait %0d expected done seen stuck", c);
    results();
  endtask
  // Read data stand one cycle after the strobe; oldest note first
  always @(posedge sys_clk)
    rd_seen <= reg_rd;
  always @(negedge sys_clk)
  begin
    if (rd_seen && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e[16])
        chk($sformatf("reg %h", e[15:8]), e[7:0], reg_rdata);
    end
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Reset contents, ignored and unmapped access, random readback
    wr(8'h90, 8'hFF);
    for (int a = 8'h88; a <= 8'h8E; a++)
      rd(8'(a), 8'h00);
    rnd = lfsr(rnd);
    wr(TIMER_MODE_CONTROL_ADDR, rnd[7:0]);
    rd(TIMER_MODE_CONTROL_ADDR, rnd[7:0]);
    wr(TIMER_RUN_FLAG_ADDR, {4'h0, rnd[11:8]});
    rd(TIMER_RUN_FLAG_ADDR, {4'h0, rnd[11:8]});
    // Free timer read at the machine-cycle spacing
    wr(TIMER_MODE_CONTROL_ADDR, 8'h01);
    wr(TIMER_RUN_FLAG_ADDR, 8'h10);
    repeat (3)
    begin
      rd(COUNT_LOW0_ADDR, 8'h00, 1'b0);
      idle(5);
    end
    // Rollover of modes 0..2 on both units; stop before the next tick
    for (int u = 0; u < 2; u++)
      for (int m = 0; m < 3; m++)
      begin
        rnd = lfsr(rnd);
        h = (m == 2) ? rnd[7:0] : 8'hFF;
        wr(TIMER_MODE_CONTROL_ADDR, 8'(m << (4 * u)));
        wr(COUNT_LOW0_ADDR + 8'(u), 8'hFF);
        wr(COUNT_HIGH0_ADDR + 8'(u), h);
        wr(TIMER_RUN_FLAG_ADDR, 8'(8'h10 << (2 * u)));
        wait_on(u);
        bus(1'b0, 1'b0, 8'h00, 8'h00, 2'(1 << u));
        rd(TIMER_RUN_FLAG_ADDR, 8'(8'h10 << (2 * u)));
        wr(TIMER_RUN_FLAG_ADDR, 8'h00);
        rd(TIMER_RUN_FLAG_ADDR, 8'h00);
        rd(COUNT_LOW0_ADDR + 8'(u), m == 0 ? 8'hE0 : (m == 1 ? 8'h00 : h));
        rd(COUNT_HIGH0_ADDR + 8'(u), m == 2 ? h : 8'h00);
      end
    // Pin counting, unit 1 gated by its interrupt pin
    for (int g = 0; g < 2; g++)
    begin
      gate_lvl <= 2'(g << 1);
      wr(TIMER_MODE_CONTROL_ADDR, 8'hD5);
      wr(COUNT_LOW0_ADDR, 8'h00);
      wr(COUNT_LOW1_ADDR, 8'h00);
      wr(TIMER_RUN_FLAG_ADDR, 8'h50);
      go <= 1'b1;
      idle(1);
      go <= 1'b0;
      wait_on(2);
      idle(24);
      rd(COUNT_LOW0_ADDR, 8'h05);
      rd(COUNT_LOW1_ADDR, g ? 8'h05 : 8'h00);
      wr(TIMER_RUN_FLAG_ADDR, 8'h00);
    end
    // Split mode: unit 1 frozen, unit 0 high half on unit 1 controls
    wr(TIMER_MODE_CONTROL_ADDR, 8'h33);
    wr(COUNT_LOW1_ADDR, 8'h66);
    wr(COUNT_HIGH1_ADDR, 8'h77);
    wr(COUNT_HIGH0_ADDR, 8'hF0);
    wr(COUNT_LOW0_ADDR, 8'h00);
    wr(TIMER_RUN_FLAG_ADDR, 8'h40);
    rd(COUNT_LOW1_ADDR, 8'h66);
    idle(5);
    rd(COUNT_LOW1_ADDR, 8'h66);
    wait_on(1);
    wr(TIMER_RUN_FLAG_ADDR, 8'h00);
    rd(COUNT_HIGH0_ADDR, 8'h00);
    rd(COUNT_LOW0_ADDR, 8'h00);
    rd(COUNT_HIGH1_ADDR, 8'h77);
    idle(3);
    @(negedge sys_clk);
    chk("overflow_flag0", 8'h00, {7'h00, overflow_flag0});
    results();
  end
endmodule // tb_dual_timer_counter
`default_nettype wire
